// ===== common/srli_pkg.sv
// Shared constants and types for the reset and lock interface
package srli_pkg;

    // Input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // Synchroniser reset: reset pins idle high, status pins idle low
    localparam logic [4:0] SYNC_RST = 5'h03;

    // Times in ns and derived cycle counts at 250 MHz
    localparam int CLK_PERIOD_NS    = 4;
    localparam int LOCK_SETTLE_NS   = 400;
    localparam int LOCK_SETTLE_CYC  =
        (LOCK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_HOLD_NS     = 64;
    localparam int INIT_HOLD_CYC    =
        (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] LOCK_SETTLE_LAST =
        CNT_W'(LOCK_SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] INIT_HOLD_LAST =
        CNT_W'(INIT_HOLD_CYC - 1);

    // Reset sequencer states
    typedef enum logic [2:0] {
        SRLI_WAIT_LOCK,
        SRLI_POR_HOLD,
        SRLI_INIT,
        SRLI_RUN,
        SRLI_WARM
    } srli_state_t;

endpackage : srli_pkg

// ===== common/srli_sync_if.sv
// Synchronised input bundle between sequencer and its synchroniser
`timescale 1ns/1ns
interface srli_sync_if;
    logic por_low;
    logic warm_low;
    logic pwr_good;
    logic pll_locked;
    logic wdt_timeout;
    modport src (output por_low, warm_low, pwr_good, pll_locked, wdt_timeout);
    modport dst (input  por_low, warm_low, pwr_good, pll_locked, wdt_timeout);
endinterface : srli_sync_if

// ===== hw/srli_sync.sv
// Three-stage input synchroniser with two-stage agreement filter
`timescale 1ns/1ns
module srli_sync (
    input  wire logic  i_clk,
    input  wire logic  i_nrst,
    input  wire logic  i_por_low,
    input  wire logic  i_warm_low,
    input  wire logic  i_pwr_good,
    input  wire logic  i_pll_locked,
    input  wire logic  i_wdt_timeout,
    srli_sync_if.src   sync
);

    localparam int N = 5;

    logic [N-1:0] raw;
    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;
    logic [N-1:0] val_r;
    logic [N-1:0] s1_nxt;
    logic [N-1:0] s2_nxt;
    logic [N-1:0] s3_nxt;
    logic [N-1:0] val_nxt;

    assign raw = {i_wdt_timeout, i_pll_locked, i_pwr_good,
                  i_warm_low, i_por_low};

    ////////////////////////////////////////////////////////////////////////
    // Per-bit filter: value changes once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_bit
            always_comb begin
                s1_nxt[g]  = raw[g];
                s2_nxt[g]  = s1_r[g];
                s3_nxt[g]  = s2_r[g];
                val_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : val_r[g];
            end
        end
    endgenerate

    // Reset inputs idle high; status inputs idle low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_r  <= srli_pkg::SYNC_RST;
            s2_r  <= srli_pkg::SYNC_RST;
            s3_r  <= srli_pkg::SYNC_RST;
            val_r <= srli_pkg::SYNC_RST;
        end else begin
            s1_r  <= s1_nxt;
            s2_r  <= s2_nxt;
            s3_r  <= s3_nxt;
            val_r <= val_nxt;
        end
    end

    assign sync.por_low     = val_r[0];
    assign sync.warm_low    = val_r[1];
    assign sync.pwr_good    = val_r[2];
    assign sync.pll_locked  = val_r[3];
    assign sync.wdt_timeout = val_r[4];

endmodule : srli_sync

// ===== hw/srli_top.sv
// Power-on and warm reset sequencer with lock indication output
`timescale 1ns/1ns
module srli_top (
    input  wire logic  i_clk,
    input  wire logic  i_nrst,
    input  wire logic  i_power_on_reset_low,
    input  wire logic  i_warm_reset_low,
    input  wire logic  i_supply_good,
    input  wire logic  i_synth_locked,
    input  wire logic  i_wdt_timeout,
    output logic       o_lock_ind,
    output logic       o_core_reset_low,
    output logic       o_init_pulse,
    output logic       o_warm_active
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    // Each pin passes three synchroniser flops and a filter flop before use
    srli_sync_if sync ();

    srli_sync u_sync (
        .i_clk         (i_clk),
        .i_nrst        (i_nrst),
        .i_por_low     (i_power_on_reset_low),
        .i_warm_low    (i_warm_reset_low),
        .i_pwr_good    (i_supply_good),
        .i_pll_locked  (i_synth_locked),
        .i_wdt_timeout (i_wdt_timeout),
        .sync          (sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Lock qualification state
    logic [srli_pkg::CNT_W-1:0] lock_cnt_r;
    logic [srli_pkg::CNT_W-1:0] lock_cnt_nxt;
    logic                       locked_r;
    logic                       locked_nxt;
    logic                       lock_ind_r;
    logic                       lock_ind_nxt;
    logic                       pwrup_ok;

    // Sequencer state
    srli_pkg::srli_state_t      state_r;
    srli_pkg::srli_state_t      state_nxt;
    logic [srli_pkg::CNT_W-1:0] cnt_r;
    logic [srli_pkg::CNT_W-1:0] cnt_nxt;
    logic                       core_rst_low_r;
    logic                       core_rst_low_nxt;
    logic                       init_pulse_r;
    logic                       init_pulse_nxt;
    logic                       warm_r;
    logic                       warm_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Lock qualification: stable lock for the settle time
    // Any drop of lock restarts the count
    always_comb begin
        lock_cnt_nxt = srli_pkg::CNT_RST;
        locked_nxt   = 1'b0;
        if (sync.pll_locked) begin
            if (lock_cnt_r == srli_pkg::LOCK_SETTLE_LAST) begin
                lock_cnt_nxt = lock_cnt_r;
                locked_nxt   = 1'b1;
            end else begin
                lock_cnt_nxt = lock_cnt_r + 8'h01;
            end
        end
    end

    // Lock requalified after chip reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_cnt_r <= srli_pkg::CNT_RST;
            locked_r   <= 1'b0;
        end else begin
            lock_cnt_r <= lock_cnt_nxt;
            locked_r   <= locked_nxt;
        end
    end

    assign pwrup_ok = locked_r && sync.pwr_good;

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer
    // WAIT_LOCK: core held until lock and supply good
    // POR_HOLD:  core held until power-on reset released
    // INIT:      core held for the init time
    // RUN:       core released, warm reset honoured
    // WARM:      core held until warm reset released
    // Lock or supply loss returns to WAIT_LOCK
    always_comb begin
        state_nxt        = state_r;
        cnt_nxt          = cnt_r;
        core_rst_low_nxt = 1'b0;
        init_pulse_nxt   = 1'b0;
        warm_nxt         = 1'b0;
        case (state_r)
            srli_pkg::SRLI_WAIT_LOCK: begin
                cnt_nxt = srli_pkg::CNT_RST;
                if (pwrup_ok) begin
                    state_nxt = srli_pkg::SRLI_POR_HOLD;
                end
            end
            srli_pkg::SRLI_POR_HOLD: begin
                cnt_nxt = srli_pkg::CNT_RST;
                if (!pwrup_ok) begin
                    state_nxt = srli_pkg::SRLI_WAIT_LOCK;
                // Init starts after lock, on release
                end else if (sync.por_low) begin
                    state_nxt      = srli_pkg::SRLI_INIT;
                    init_pulse_nxt = 1'b1;
                end
            end
            srli_pkg::SRLI_INIT: begin
                // Hold core in reset for init time
                if (!sync.por_low) begin
                    state_nxt = srli_pkg::SRLI_POR_HOLD;
                end else if (!pwrup_ok) begin
                    state_nxt = srli_pkg::SRLI_WAIT_LOCK;
                end else if (cnt_r == srli_pkg::INIT_HOLD_LAST) begin
                    state_nxt        = srli_pkg::SRLI_RUN;
                    core_rst_low_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end
            srli_pkg::SRLI_RUN: begin
                core_rst_low_nxt = 1'b1;
                if (!sync.por_low) begin
                    state_nxt        = srli_pkg::SRLI_POR_HOLD;
                    core_rst_low_nxt = 1'b0;
                end else if (!pwrup_ok) begin
                    state_nxt        = srli_pkg::SRLI_WAIT_LOCK;
                    core_rst_low_nxt = 1'b0;
                // Warm reset gated by power-up state
                end else if (!sync.warm_low) begin
                    state_nxt        = srli_pkg::SRLI_WARM;
                    core_rst_low_nxt = 1'b0;
                    warm_nxt         = 1'b1;
                end
            end
            srli_pkg::SRLI_WARM: begin
                warm_nxt = 1'b1;
                cnt_nxt  = srli_pkg::CNT_RST;
                if (!sync.por_low) begin
                    state_nxt = srli_pkg::SRLI_POR_HOLD;
                    warm_nxt  = 1'b0;
                end else if (!pwrup_ok) begin
                    state_nxt = srli_pkg::SRLI_WAIT_LOCK;
                    warm_nxt  = 1'b0;
                end else if (sync.warm_low) begin
                    state_nxt      = srli_pkg::SRLI_INIT;
                    init_pulse_nxt = 1'b1;
                    warm_nxt       = 1'b0;
                end
            end
            default: begin
                state_nxt = srli_pkg::SRLI_WAIT_LOCK;
                cnt_nxt   = srli_pkg::CNT_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer registers
    // Core held in reset from chip reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r        <= srli_pkg::SRLI_WAIT_LOCK;
            cnt_r          <= srli_pkg::CNT_RST;
            core_rst_low_r <= 1'b0;
            init_pulse_r   <= 1'b0;
            warm_r         <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            cnt_r          <= cnt_nxt;
            core_rst_low_r <= core_rst_low_nxt;
            init_pulse_r   <= init_pulse_nxt;
            warm_r         <= warm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock indication output
    // Independent of power-on reset, the board waits on it
    always_comb begin
        lock_ind_nxt = locked_r && !sync.wdt_timeout;
    end

    // Lock output low through chip reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lock_ind_r <= 1'b0;
        end else begin
            lock_ind_r <= lock_ind_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    assign o_lock_ind       = lock_ind_r;
    assign o_core_reset_low = core_rst_low_r;
    assign o_init_pulse     = init_pulse_r;
    assign o_warm_active    = warm_r;

endmodule : srli_top

// ===== dv/srli_props.sv
// Port checker of the reset sequencer
`timescale 1ns/1ns
module srli_props (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_power_on_reset_low,
    input  wire logic i_warm_reset_low,
    input  wire logic i_supply_good,
    input  wire logic i_synth_locked,
    input  wire logic i_wdt_timeout,
    input  wire logic o_lock_ind,
    input  wire logic o_core_reset_low,
    input  wire logic o_init_pulse,
    input  wire logic o_warm_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic [7:0] ok_cnt_r;
    logic [7:0] ok_cnt_nxt;
    // Cycles of steady lock without watchdog
    always_comb begin
        ok_cnt_nxt = ok_cnt_r;
        if (!i_synth_locked || i_wdt_timeout)
            ok_cnt_nxt = 8'h00;
        else if (ok_cnt_r != 8'hFF)
            ok_cnt_nxt = ok_cnt_r + 8'h01;
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst)
            ok_cnt_r <= 8'h00;
        else
            ok_cnt_r <= ok_cnt_nxt;
    end
    property p_lock_on;
        ok_cnt_r >= 8'h78 |-> o_lock_ind;
    endproperty
    property p_lock_qual;
        o_lock_ind |-> $past(i_synth_locked, 8);
    endproperty
    property p_wdt_drop;
        i_wdt_timeout [*8] |-> !o_lock_ind;
    endproperty
    property p_por_gate;
        (!i_power_on_reset_low) [*8] |-> !o_warm_active && !o_core_reset_low;
    endproperty
    property p_lock_gate;
        (!i_synth_locked) [*8] |-> !o_warm_active && !o_core_reset_low;
    endproperty
    property p_warm_entry;
        $rose(o_warm_active) |-> $past(o_core_reset_low) && !o_core_reset_low;
    endproperty
    property p_init_seq;
        o_init_pulse |-> ($past(i_synth_locked, 8) && !o_core_reset_low)
            ##1 (!o_init_pulse && !o_core_reset_low) [*8];
    endproperty
    property p_release;
        $rose(o_core_reset_low) |->
            $past(i_synth_locked, 8) && !o_warm_active;
    endproperty
    a_lock_on: assert property (p_lock_on)
        else $error("lock output missing");
    a_lock_qual: assert property (p_lock_qual)
        else $error("lock output without lock");
    a_wdt_drop: assert property (p_wdt_drop)
        else $error("lock output high in watchdog");
    a_por_gate: assert property (p_por_gate)
        else $error("running while power-on reset low");
    a_lock_gate: assert property (p_lock_gate)
        else $error("running without lock");
    a_warm_entry: assert property (p_warm_entry)
        else $error("warm reset taken outside run");
    a_init_seq: assert property (p_init_seq)
        else $error("init sequence broken");
    a_release: assert property (p_release)
        else $error("core released without lock");
    c_lock: cover property ($rose(o_lock_ind));
    c_init: cover property (o_init_pulse);
    c_warm: cover property ($rose(o_warm_active));
endmodule : srli_props

bind srli_top srli_props chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_power_on_reset_low(i_power_on_reset_low),
    .i_warm_reset_low(i_warm_reset_low), .i_supply_good(i_supply_good),
    .i_synth_locked(i_synth_locked), .i_wdt_timeout(i_wdt_timeout),
    .o_lock_ind(o_lock_ind), .o_core_reset_low(o_core_reset_low),
    .o_init_pulse(o_init_pulse), .o_warm_active(o_warm_active));

// ===== dv/srli_board.sv
// Board reset logic model
`timescale 1ns/1ns
module srli_board (
    input  wire logic i_clk,
    input  wire logic i_lock_ind,
    input  wire logic i_warm_req,
    output logic      o_por_low,
    output logic      o_warm_low
);
    logic [1:0] lk_r;
    initial begin
        o_por_low = 1'b0;
        o_warm_low = 1'b1;
        lk_r = 2'h0;
    end
    always @(posedge i_clk) begin
        lk_r <= {lk_r[0], i_lock_ind};
        if (lk_r[1])
            o_por_low <= 1'b1;
        o_warm_low <= !i_warm_req;
    end
endmodule : srli_board

// ===== dv/srli_top_tb.sv
// Self-checking bench of the reset sequencer
`timescale 1ns/1ns
module srli_top_tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_supply_good = 1'b0;
    logic i_synth_locked = 1'b0;
    logic i_wdt_timeout = 1'b0;
    logic warm_req = 1'b0;
    logic por_low, warm_low, lock_ind, core_low, init_p, warm_act;
    int n_mismatch = 0;
    int compares = 0;
    always #2 i_clk = ~i_clk;
    srli_board brd_u (.i_clk(i_clk), .i_lock_ind(lock_ind),
        .i_warm_req(warm_req), .o_por_low(por_low), .o_warm_low(warm_low));
    srli_top dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_power_on_reset_low(por_low), .i_warm_reset_low(warm_low),
        .i_supply_good(i_supply_good), .i_synth_locked(i_synth_locked),
        .i_wdt_timeout(i_wdt_timeout), .o_lock_ind(lock_ind),
        .o_core_reset_low(core_low), .o_init_pulse(init_p),
        .o_warm_active(warm_act));
    task automatic chk(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    // Watched outputs by number
    localparam int W_LOCK = 0;
    localparam int W_INIT = 1;
    localparam int W_CORE = 2;
    function automatic logic pick(input int sel);
        case (sel)
            W_LOCK: pick = lock_ind;
            W_INIT: pick = init_p;
            default: pick = core_low;
        endcase
    endfunction : pick
    task automatic wait_for(input int sel, input logic v, input int n);
        int k;
        k = 0;
        while (pick(sel) !== v && k < n) begin
            @(posedge i_clk);
            #1;
            k++;
        end
    endtask : wait_for
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic t_power_up();
        @(posedge i_clk);
        i_supply_good <= 1'b1;
        i_synth_locked <= 1'b1;
        wait_for(W_LOCK, 1'b1, 200);
        chk(lock_ind, 1'b1, "lock not shown");
        chk(core_low, 1'b0, "core out of reset early");
        wait_for(W_INIT, 1'b1, 40);
        chk(init_p, 1'b1, "no init pulse");
        wait_for(W_CORE, 1'b1, 40);
        chk(core_low, 1'b1, "core not released");
        $display("power-up test done");
    endtask : t_power_up
    task automatic t_warm();
        @(posedge i_clk);
        warm_req <= 1'b1;
        repeat (12) @(posedge i_clk);
        #1;
        chk(warm_act, 1'b1, "warm reset ignored");
        chk(core_low, 1'b0, "core kept running");
        @(posedge i_clk);
        warm_req <= 1'b0;
        wait_for(W_CORE, 1'b1, 60);
        chk(core_low, 1'b1, "no release after warm");
        $display("warm test done");
    endtask : t_warm
    task automatic t_wdt();
        @(posedge i_clk);
        i_wdt_timeout <= 1'b1;
        repeat (12) @(posedge i_clk);
        #1;
        chk(lock_ind, 1'b0, "lock kept in watchdog");
        @(posedge i_clk);
        i_wdt_timeout <= 1'b0;
        wait_for(W_LOCK, 1'b1, 200);
        chk(lock_ind, 1'b1, "lock not restored");
        wait_for(W_CORE, 1'b1, 300);
        chk(core_low, 1'b1, "core lost in watchdog");
        $display("watchdog test done");
    endtask : t_wdt
    task automatic t_gated();
        @(posedge i_clk);
        i_synth_locked <= 1'b0;
        repeat (12) @(posedge i_clk);
        warm_req <= 1'b1;
        repeat (12) @(posedge i_clk);
        #1;
        chk(core_low, 1'b0, "running without lock");
        chk(lock_ind, 1'b0, "lock shown while unlocked");
        chk(warm_act, 1'b0, "warm taken while unlocked");
        @(posedge i_clk);
        warm_req <= 1'b0;
        repeat (12) @(posedge i_clk);
        i_synth_locked <= 1'b1;
        wait_for(W_CORE, 1'b1, 300);
        chk(core_low, 1'b1, "no restart on relock");
        $display("lock gating test done");
    endtask : t_gated
    initial begin
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_power_up();
        t_warm();
        t_wdt();
        t_gated();
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge i_clk);
        n_mismatch++;
        complete_run();
    end
endmodule : srli_top_tb
